// ### rtl/csp_pkg.sv
package csp_pkg;

    // ----------------------------------------------------------------
    // bus geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ----------------------------------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] SUPPLY_CTRL_OFF = 8'h10;
    localparam logic [7:0] CLOCK_PM_OFF = 8'h20;
    localparam logic [7:0] CARD_CAP_OFF = 8'h30;

    // ----------------------------------------------------------------
    // socket_supply_control fields
    // ----------------------------------------------------------------
    localparam int PROG_LSB = 0;
    localparam int CORE_LSB = 4;
    localparam int STOP_POLICY_BIT = 7;
    localparam int SUPPLY_ONE_BIT = 10;
    localparam int SUPPLY_W = 3;

    // ----------------------------------------------------------------
    // socket_clock_power_management fields
    // ----------------------------------------------------------------
    localparam int THR_SEL_BIT = 0;
    localparam int THR_EN_BIT = 16;
    localparam int MODE_BIT = 24;
    localparam int ACCESS_BIT = 25;

    // ----------------------------------------------------------------
    // card_capability_control fields
    // ----------------------------------------------------------------
    localparam int CAP_W = 4;
    localparam int CAP_LSB = 0;
    localparam int CAP_5V = 0;
    localparam int CAP_3V3 = 1;
    localparam int CAP_XV = 2;
    localparam int CAP_YV = 3;
    localparam int BAD_REQ_BIT = 8;
    localparam int RETEST_BIT = 14;
    localparam int POWER_EN_BIT = 15;

    // ----------------------------------------------------------------
    // supply request codes
    // ----------------------------------------------------------------
    localparam logic [2:0] SUPPLY_OFF = 3'h0;
    localparam logic [2:0] PROG_12V = 3'h1;
    localparam logic [2:0] SUPPLY_5V = 3'h2;
    localparam logic [2:0] SUPPLY_3V3 = 3'h3;
    localparam logic [2:0] SUPPLY_XV = 3'h4;
    localparam logic [2:0] SUPPLY_YV = 3'h5;

    // ----------------------------------------------------------------
    // reset values and timing
    // ----------------------------------------------------------------
    localparam logic [31:0] SUPPLY_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] CLOCK_PM_RST = 32'h0000_0000;
    localparam logic [3:0] CAP_RST = 4'h0;
    localparam int SLOW_FACTOR = 16;
    // synced caps are not valid until the pin synchroniser has filled
    localparam logic [2:0] INTERROGATE_WAIT = 3'h6;

    typedef enum logic [2:0] {
        CSP_CLK_RUN = 3'b001,
        CSP_CLK_SLOW = 3'b010,
        CSP_CLK_STOP = 3'b100
    } csp_clk_state_t;

endpackage

// ### rtl/csp_pin_sync.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// three-stage pin synchroniser, change taken when stages 2 and 3 agree
// ----------------------------------------------------------------
module csp_pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic [WIDTH-1:0] i_pin,
    output logic [WIDTH-1:0] o_level
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] level_next;

    always_comb begin
        level_next = o_level;
        for (int b = 0; b < WIDTH; b++) begin
            if (s2_reg[b] == s3_reg[b]) begin
                level_next[b] = s3_reg[b];
            end
        end
    end

    // stage 1 feeds only stage 2: no logic may look at a metastable node
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1_reg <= INIT;
            s2_reg <= INIT;
            s3_reg <= INIT;
            o_level <= INIT;
        end else if (i_ce) begin
            s1_reg <= i_pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            o_level <= level_next;
        end
    end
endmodule // csp_pin_sync

`default_nettype wire

// ### rtl/csp_socket_power.sv
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module csp_socket_power
#(
    parameter int SLOW_DIV = csp_pkg::SLOW_FACTOR
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_ce,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [csp_pkg::ADDR_W-1:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [csp_pkg::DATA_W-1:0] i_wb_dat,
    output logic o_wb_ack,
    output logic [csp_pkg::DATA_W-1:0] o_wb_dat,
    input wire logic i_host_bus_reset_pin_n,
    input wire logic i_wake_enable,
    input wire logic [csp_pkg::CAP_W-1:0] i_card_caps,
    input wire logic i_card_idle,
    input wire logic i_host_clkrun_stopping,
    input wire logic i_card_access,
    output logic [2:0] o_core_supply,
    output logic [2:0] o_program_supply,
    output logic o_card_clock_enable,
    output logic o_card_clock_stopped,
    output logic o_card_clock_slowed
);
    import csp_pkg::*;

    // ----------------------------------------------------------------
    // reset release and pin synchronisers
    // ----------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_n_reg;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    localparam int PIN_W = CAP_W + 5;
    logic [PIN_W-1:0] pins_sync;
    logic host_reset_n_s;
    logic wake_s;
    logic idle_s;
    logic host_stop_s;
    logic access_s;
    logic [CAP_W-1:0] caps_s;

    csp_pin_sync #(
        .WIDTH(PIN_W),
        .INIT({{(PIN_W-1){1'b0}}, 1'b1})
    ) u_pins (
        .i_clk(i_clk),
        .i_rst_n(rst_n_reg),
        .i_ce(i_ce),
        .i_pin({i_card_caps, i_card_access, i_host_clkrun_stopping, i_card_idle, i_wake_enable,
                i_host_bus_reset_pin_n}),
        .o_level(pins_sync)
    );

    assign host_reset_n_s = pins_sync[0];
    assign wake_s = pins_sync[1];
    assign idle_s = pins_sync[2];
    assign host_stop_s = pins_sync[3];
    assign access_s = pins_sync[4];
    assign caps_s = pins_sync[PIN_W-1:5];

    // ----------------------------------------------------------------
    // supply acceptability check
    // ----------------------------------------------------------------
    // reserved codes are never passed on: they map to off
    function automatic logic [2:0] gate_supply(input logic [2:0] req, input logic [CAP_W-1:0] cap,
                                               input logic prog, input logic core_on);
        logic ok;
        case (req)
            PROG_12V: ok = prog && core_on;
            SUPPLY_5V: ok = cap[CAP_5V];
            SUPPLY_3V3: ok = cap[CAP_3V3];
            SUPPLY_XV: ok = cap[CAP_XV];
            SUPPLY_YV: ok = cap[CAP_YV];
            default: ok = 1'b0;
        endcase
        return ok ? req : SUPPLY_OFF;
    endfunction

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic policy_reg, policy_next;
    logic [2:0] core_req_reg, core_req_next;
    logic [2:0] prog_req_reg, prog_req_next;
    logic thr_en_reg, thr_en_next;
    logic thr_sel_reg, thr_sel_next;
    logic access_seen_reg, access_seen_next;
    logic [CAP_W-1:0] cap_reg, cap_next;
    logic power_en_reg, power_en_next;
    logic [2:0] interrogate_reg, interrogate_next;
    logic bad_req_reg, bad_req_next;
    logic ack_next;
    logic [DATA_W-1:0] rdata_next;
    logic [2:0] core_out_next;
    logic [2:0] prog_out_next;
    csp_clk_state_t clk_state_reg, clk_state_next;
    logic [3:0] slow_cnt_reg, slow_cnt_next;
    logic clk_en_next;
    logic access;
    logic wr_en;
    logic rd_en;
    logic attempt;

    assign access = i_wb_cyc && i_wb_stb && !o_wb_ack;
    assign wr_en = access && i_wb_we;
    assign rd_en = access && !i_wb_we;

    always_comb begin
        policy_next = policy_reg;
        core_req_next = core_req_reg;
        prog_req_next = prog_req_reg;
        thr_en_next = thr_en_reg;
        thr_sel_next = thr_sel_reg;
        access_seen_next = access_seen_reg;
        cap_next = cap_reg;
        power_en_next = power_en_reg;
        interrogate_next = interrogate_reg;
        bad_req_next = bad_req_reg;
        ack_next = access;
        rdata_next = '0;

        // ----------------------------------------------------------------
        // read mux
        // ----------------------------------------------------------------
        case (i_wb_adr)
            SUPPLY_CTRL_OFF: begin
                rdata_next[SUPPLY_ONE_BIT] = 1'b1;
                rdata_next[STOP_POLICY_BIT] = policy_reg;
                rdata_next[CORE_LSB +: SUPPLY_W] = core_req_reg;
                rdata_next[PROG_LSB +: SUPPLY_W] = prog_req_reg;
            end
            CLOCK_PM_OFF: begin
                rdata_next[ACCESS_BIT] = access_seen_reg;
                rdata_next[MODE_BIT] = o_card_clock_stopped || o_card_clock_slowed;
                rdata_next[THR_EN_BIT] = thr_en_reg;
                rdata_next[THR_SEL_BIT] = thr_sel_reg;
            end
            CARD_CAP_OFF: begin
                rdata_next[CAP_LSB +: CAP_W] = cap_reg;
                rdata_next[BAD_REQ_BIT] = bad_req_reg;
                rdata_next[POWER_EN_BIT] = power_en_reg;
            end
            default: rdata_next = '0;
        endcase
        if (!rd_en) begin
            rdata_next = '0;
        end

        // ----------------------------------------------------------------
        // writes; unlisted bits have no storage and so ignore writes
        // ----------------------------------------------------------------
        if (wr_en && i_wb_adr == SUPPLY_CTRL_OFF && i_wb_sel[0]) begin
            policy_next = i_wb_dat[STOP_POLICY_BIT];
            core_req_next = i_wb_dat[CORE_LSB +: SUPPLY_W];
            prog_req_next = i_wb_dat[PROG_LSB +: SUPPLY_W];
        end
        if (wr_en && i_wb_adr == CLOCK_PM_OFF) begin
            if (i_wb_sel[2]) begin
                thr_en_next = i_wb_dat[THR_EN_BIT];
            end
            if (i_wb_sel[0]) begin
                thr_sel_next = i_wb_dat[THR_SEL_BIT];
            end
        end
        if (wr_en && i_wb_adr == CARD_CAP_OFF) begin
            if (i_wb_sel[0]) begin
                cap_next = i_wb_dat[CAP_LSB +: CAP_W];
                if (i_wb_dat[CAP_LSB +: CAP_W] != '0) begin
                    power_en_next = 1'b0;
                end
            end
            if (i_wb_sel[1] && i_wb_dat[BAD_REQ_BIT]) begin
                bad_req_next = 1'b0;
            end
            if (i_wb_sel[1] && i_wb_dat[RETEST_BIT]) begin
                interrogate_next = 3'h1;
            end
        end

        // wait out the pin synchroniser before capturing the card's capabilities
        if (interrogate_reg != 3'h0) begin
            interrogate_next = interrogate_reg - 3'h1;
        end
        if (interrogate_reg == 3'h1) begin
            cap_next = caps_s;
            power_en_next = 1'b1;
        end

        // read side effect first, so a simultaneous access keeps the bit
        if (rd_en && i_wb_adr == CLOCK_PM_OFF) begin
            access_seen_next = 1'b0;
        end
        if (access_s) begin
            access_seen_next = 1'b1;
        end

        // a request the card refuses is flagged; set wins over clear
        if (power_en_reg && ((core_req_reg != SUPPLY_OFF && core_out_next == SUPPLY_OFF) ||
                             (prog_req_reg != SUPPLY_OFF && prog_out_next == SUPPLY_OFF))) begin
            bad_req_next = 1'b1;
        end

        // bus reset: wake context survives it only while wake is enabled
        if (!host_reset_n_s) begin
            policy_next = 1'b0;
            thr_en_next = 1'b0;
            thr_sel_next = 1'b0;
            if (!wake_s) begin
                core_req_next = SUPPLY_OFF;
                prog_req_next = SUPPLY_OFF;
            end
        end
    end

    // ----------------------------------------------------------------
    // supply outputs
    // ----------------------------------------------------------------
    always_comb begin
        core_out_next = SUPPLY_OFF;
        prog_out_next = SUPPLY_OFF;
        if (power_en_reg) begin
            core_out_next = gate_supply(core_req_reg, cap_reg, 1'b0, 1'b0);
            prog_out_next = gate_supply(prog_req_reg, cap_reg, 1'b1,
                                        core_out_next != SUPPLY_OFF);
        end
    end

    // ----------------------------------------------------------------
    // card clock-run state machine
    // ----------------------------------------------------------------
    // policy 0 waits for the host side to be stopping too
    assign attempt = thr_en_reg && idle_s && (policy_reg || host_stop_s);

    always_comb begin
        clk_state_next = clk_state_reg;
        slow_cnt_next = slow_cnt_reg;
        unique case (clk_state_reg)
            CSP_CLK_RUN: begin
                if (attempt) begin
                    clk_state_next = thr_sel_reg ? CSP_CLK_SLOW : CSP_CLK_STOP;
                    slow_cnt_next = '0;
                end
            end
            CSP_CLK_SLOW: begin
                slow_cnt_next = (slow_cnt_reg == 4'(SLOW_DIV - 1)) ? 4'h0 : slow_cnt_reg + 4'h1;
                if (!attempt || !thr_sel_reg) begin
                    clk_state_next = CSP_CLK_RUN;
                end
            end
            CSP_CLK_STOP: begin
                if (!attempt || thr_sel_reg) begin
                    clk_state_next = CSP_CLK_RUN;
                end
            end
        endcase
        // one card clock pulse in SLOW_DIV (sixteen by default) while slowed
        clk_en_next = (clk_state_next == CSP_CLK_RUN) ||
                      (clk_state_next == CSP_CLK_SLOW && slow_cnt_next == 4'h0);
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            policy_reg <= SUPPLY_CTRL_RST[STOP_POLICY_BIT];
            core_req_reg <= SUPPLY_CTRL_RST[CORE_LSB +: SUPPLY_W];
            prog_req_reg <= SUPPLY_CTRL_RST[PROG_LSB +: SUPPLY_W];
            thr_en_reg <= CLOCK_PM_RST[THR_EN_BIT];
            thr_sel_reg <= CLOCK_PM_RST[THR_SEL_BIT];
            access_seen_reg <= CLOCK_PM_RST[ACCESS_BIT];
            cap_reg <= CAP_RST;
            power_en_reg <= 1'b0;
            interrogate_reg <= INTERROGATE_WAIT;
            bad_req_reg <= 1'b0;
            o_wb_ack <= 1'b0;
            o_wb_dat <= '0;
            o_core_supply <= SUPPLY_OFF;
            o_program_supply <= SUPPLY_OFF;
            clk_state_reg <= CSP_CLK_RUN;
            slow_cnt_reg <= 4'h0;
            o_card_clock_enable <= 1'b1;
            o_card_clock_stopped <= 1'b0;
            o_card_clock_slowed <= 1'b0;
        end else if (i_ce) begin
            policy_reg <= policy_next;
            core_req_reg <= core_req_next;
            prog_req_reg <= prog_req_next;
            thr_en_reg <= thr_en_next;
            thr_sel_reg <= thr_sel_next;
            access_seen_reg <= access_seen_next;
            cap_reg <= cap_next;
            power_en_reg <= power_en_next;
            interrogate_reg <= interrogate_next;
            bad_req_reg <= bad_req_next;
            o_wb_ack <= ack_next;
            o_wb_dat <= rdata_next;
            o_core_supply <= core_out_next;
            o_program_supply <= prog_out_next;
            clk_state_reg <= clk_state_next;
            slow_cnt_reg <= slow_cnt_next;
            o_card_clock_enable <= clk_en_next;
            o_card_clock_stopped <= (clk_state_next == CSP_CLK_STOP);
            o_card_clock_slowed <= (clk_state_next == CSP_CLK_SLOW);
        end
    end
endmodule // csp_socket_power

`default_nettype wire

// ### tb/csp_socket_power_sva.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// port checker
// ----------------------------------------------------------------
module csp_socket_power_sva (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic o_wb_ack,
    input wire logic [31:0] o_wb_dat,
    input wire logic [2:0] o_core_supply,
    input wire logic [2:0] o_program_supply,
    input wire logic o_card_clock_enable,
    input wire logic o_card_clock_stopped,
    input wire logic o_card_clock_slowed
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    ack_answers_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack)
        else $error("ack missing or longer than one cycle");
    supply_map_a: assert property (o_wb_ack && !i_wb_we && i_wb_adr == 8'h10 |->
        o_wb_dat[10] && o_wb_dat[31:11] == 0 && o_wb_dat[9:8] == 0 && !o_wb_dat[3])
        else $error("supply control fixed bits wrong");
    pm_map_a: assert property (o_wb_ack && !i_wb_we && i_wb_adr == 8'h20 |->
        o_wb_dat[31:26] == 0 && o_wb_dat[23:17] == 0 && o_wb_dat[15:1] == 0)
        else $error("power management reserved bits nonzero");
    core_code_a: assert property (o_core_supply inside {3'h0, 3'h2, 3'h3, 3'h4, 3'h5})
        else $error("reserved core code driven");
    prog_code_a: assert property (!(o_program_supply inside {3'h6, 3'h7}))
        else $error("reserved program code driven");
    prog_high_a: assert property (o_program_supply == 3'h1 |-> o_core_supply != 3'h0)
        else $error("12 V program supply without core supply");
    stop_gate_a: assert property (o_card_clock_stopped |-> !o_card_clock_enable && !o_card_clock_slowed)
        else $error("stopped clock still enabled");
    slow_pulse_a: assert property (o_card_clock_slowed && o_card_clock_enable ##1 o_card_clock_slowed |-> !o_card_clock_enable)
        else $error("slowed clock enabled two cycles running");
    run_free_a: assert property (!o_card_clock_stopped && !o_card_clock_slowed |-> o_card_clock_enable)
        else $error("running clock not enabled");
endmodule // csp_socket_power_sva

bind csp_socket_power csp_socket_power_sva i_sva (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat),
    .o_core_supply(o_core_supply), .o_program_supply(o_program_supply), .o_card_clock_enable(o_card_clock_enable),
    .o_card_clock_stopped(o_card_clock_stopped), .o_card_clock_slowed(o_card_clock_slowed));

`default_nettype wire

// ### tb/csp_card_model.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// card and power switch
// ----------------------------------------------------------------
module csp_card_model (
    input wire logic i_clk,
    input wire logic [3:0] i_caps_cfg,
    input wire logic i_idle_cfg,
    input wire logic i_access_cfg,
    input wire logic [2:0] i_core_supply,
    input wire logic i_clock_enable,
    output logic [3:0] o_card_caps,
    output logic o_card_idle,
    output logic o_card_access
);
    initial begin
        o_card_caps = i_caps_cfg;
        o_card_idle = 1'b0;
        o_card_access = 1'b0;
    end
    always @(posedge i_clk) begin
        o_card_caps <= i_caps_cfg;
        // unpowered card does nothing, so it is idle
        o_card_idle <= i_idle_cfg || i_core_supply == 3'h0;
        // no access without supply and clock
        o_card_access <= i_access_cfg && i_core_supply != 3'h0 && i_clock_enable;
    end
endmodule // csp_card_model

`default_nettype wire

// ### tb/cardbus_socket_power_control_test.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin fail_count++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end

module cardbus_socket_power_control_test;
    import csp_pkg::*;
    localparam int SD = 4;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_wb_cyc = 1'b0;
    logic i_wb_stb = 1'b0;
    logic i_wb_we = 1'b0;
    logic [7:0] i_wb_adr = 8'h00;
    logic [31:0] i_wb_dat = 32'h0;
    logic o_wb_ack, o_en, o_stop, o_slow, idle, acc, c_idle, c_acc, hrst_n = 1'b1, wake = 1'b0, hstop = 1'b0;
    logic [31:0] o_wb_dat, rdat, d;
    logic [2:0] o_core, o_prog;
    logic [3:0] caps = 4'h3, c_caps;
    int fail_count = 0;
    int compares = 0;
    int gc, cnt;

    always #5 i_clk = ~i_clk;

    csp_card_model i_card (.i_clk(i_clk), .i_caps_cfg(caps), .i_idle_cfg(idle), .i_access_cfg(acc),
        .i_core_supply(o_core), .i_clock_enable(o_en), .o_card_caps(c_caps), .o_card_idle(c_idle),
        .o_card_access(c_acc));
    csp_socket_power #(.SLOW_DIV(SD)) i_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_ce(1'b1),
        .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(4'hf),
        .i_wb_dat(i_wb_dat), .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat), .i_host_bus_reset_pin_n(hrst_n),
        .i_wake_enable(wake), .i_card_caps(c_caps), .i_card_idle(c_idle), .i_host_clkrun_stopping(hstop),
        .i_card_access(c_acc), .o_core_supply(o_core), .o_program_supply(o_prog),
        .o_card_clock_enable(o_en), .o_card_clock_stopped(o_stop), .o_card_clock_slowed(o_slow));

    // ----------------------------------------------------------------
    // reference model and bus tasks
    // ----------------------------------------------------------------
    function automatic int gate_core(int c, int k);
        return (c >= 2 && c <= 5 && k[c-2]) ? c : 0;
    endfunction
    function automatic int gate_prog(int p, int g, int k);
        return (p == 1) ? ((g != 0) ? 1 : 0) : gate_core(p, k);
    endfunction
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] dw);
        int n;
        n = 0;
        @(posedge i_clk);
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we <= we;
        i_wb_adr <= a;
        i_wb_dat <= dw;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_wb_ack !== 1'b1 && n < 50);
        if (n >= 50) fail_count++;
        rdat = o_wb_dat;
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
    endtask
    // ends off the edge, so outputs are sampled once settled
    task automatic look(int n);
        repeat (n) @(posedge i_clk);
        @(negedge i_clk);
    endtask
    task test_done;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        #200000;
        fail_count++;
        test_done;
    end

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        idle = 1'b0;
        acc = 1'b0;
        void'($urandom(32'h6c768e46));
        repeat (10) @(posedge i_clk);
        i_reset_n <= 1'b1;
        repeat (12) @(posedge i_clk);
        bus(0, 8'h10, 0);
        `CHK("ctrl_rst", 32'h400, rdat)
        bus(0, 8'h20, 0);
        `CHK("pm_rst", 32'h0, rdat)
        for (int i = 0; i < 64; i++) begin
            d = $urandom();
            d[6:4] = i[5:3];
            d[2:0] = i[2:0];
            bus(1, 8'h10, d);
            bus(0, 8'h10, 0);
            `CHK("ctrl", 32'h400 | (d & 32'hf7), rdat)
            look(2);
            gc = gate_core(i / 8, 3);
            `CHK("core", gc, o_core)
            `CHK("prog", gate_prog(i % 8, gc, 3), o_prog)
        end
        bus(1, 8'h44, 32'hffffffff);
        bus(0, 8'h44, 0);
        `CHK("unmapped", 32'h0, rdat)
        bus(1, 8'h10, 32'h33);
        bus(1, 8'h30, 32'h1);
        look(3);
        `CHK("forced", 0, o_core)
        bus(1, 8'h30, 32'h4000);
        look(6);
        `CHK("retest", 3, o_core)
        bus(0, 8'h30, 0);
        `CHK("caps", 32'h8003, rdat & 32'h800f)
        bus(1, 8'h20, 32'hffffffff);
        bus(0, 8'h20, 0);
        `CHK("pm_wr", 32'h10001, rdat)
        idle <= 1'b1;
        bus(1, 8'h10, 32'hb3);
        bus(1, 8'h20, 32'h10000);
        look(10);
        `CHK("stop", 2'b10, {o_stop, o_en})
        bus(1, 8'h20, 32'h10001);
        look(10);
        cnt = 0;
        for (int k = 0; k < 64; k++) begin
            @(negedge i_clk);
            if (o_slow === 1'b1 && o_en === 1'b1) cnt++;
        end
        `CHK("slow", 64 / SD, cnt)
        bus(0, 8'h20, 0);
        `CHK("mode", 32'h1010001, rdat & 32'h1010001)
        bus(1, 8'h20, 32'h1);
        look(10);
        `CHK("off", 3'b001, {o_stop, o_slow, o_en})
        bus(1, 8'h10, 32'h33);
        bus(1, 8'h20, 32'h10000);
        look(10);
        `CHK("coupled", 0, o_stop)
        @(posedge i_clk);
        hstop <= 1'b1;
        look(10);
        `CHK("host_stop", 1, o_stop)
        bus(1, 8'h20, 32'h0);
        idle <= 1'b0;
        hstop <= 1'b0;
        acc <= 1'b1;
        repeat (3) @(posedge i_clk);
        acc <= 1'b0;
        look(8);
        bus(0, 8'h20, 0);
        `CHK("access", 1, rdat[25])
        bus(0, 8'h20, 0);
        `CHK("access_clr", 0, rdat[25])
        for (int k = 1; k >= 0; k--) begin
            bus(1, 8'h10, 32'hb3);
            wake <= k[0];
            repeat (6) @(posedge i_clk);
            hrst_n <= 1'b0;
            repeat (8) @(posedge i_clk);
            hrst_n <= 1'b1;
            repeat (8) @(posedge i_clk);
            bus(0, 8'h10, 0);
            `CHK("wake", (k == 1) ? 32'h433 : 32'h400, rdat)
        end
        test_done;
    end
endmodule // cardbus_socket_power_control_test

`default_nettype wire
